// ===== logic/gp_codec.v
// 8b/10b encoder and disparity-checking decoder shared by both directions of the PCS
`include "gp_regs.vh"
module gp_codec
(
	input  wire       pclk,
	input  wire       presetn,
	input  wire [7:0] tx_data,
	input  wire       tx_k,
	output reg  [9:0] tx_code,
	output wire       tx_disp,
	input  wire [9:0] rx_code,
	output reg  [7:0] rx_data,
	output reg        rx_k,
	output reg        rx_bad
);
	// 6b sub-blocks D31..D0 in negative-disparity form, abcdei with a at the top
	localparam [191:0] TAB6 = {6'b101011, 6'b011110, 6'b101110, 6'b001110, 6'b110110, 6'b010110, 6'b100110,
		6'b110011, 6'b111010, 6'b011010, 6'b101010, 6'b001011, 6'b110010, 6'b010011, 6'b100011, 6'b011011,
		6'b010111, 6'b011100, 6'b101100, 6'b001101, 6'b110100, 6'b010101, 6'b100101, 6'b111001, 6'b111000,
		6'b011001, 6'b101001, 6'b110101, 6'b110001, 6'b101101, 6'b011101, 6'b100111};
	// 4b sub-blocks D.x.7..D.x.0, negative-disparity form, fghj
	localparam [31:0] TAB4 = {4'b1110, 4'b0110, 4'b1010, 4'b1101, 4'b1100, 4'b0101, 4'b1001, 4'b1011};
	// The twelve legal special code groups
	localparam [95:0] K_LIST = {`GP_K30_7, `GP_K29_7, `GP_K27_7, `GP_K23_7, 8'hfc, 8'hdc, `GP_K28_5, 8'h9c,
		8'h7c, 8'h5c, 8'h3c, 8'h1c};

	reg        tx_rd;
	reg        rx_rd;
	reg [10:0] cand;
	reg [7:0]  dec_data;
	reg        dec_k;
	reg        dec_hit;
	reg        dec_rd;
	integer    i;

	assign tx_disp = tx_rd;

	// Number of ones in a sub-block
	function [2:0] weight;
		input [5:0] v;
		integer j;
		begin
			weight = 3'd0;
			for (j = 0; j < 6; j = j + 1)
				weight = weight + {2'b00, v[j]};
		end
	endfunction

	// Returns {running disparity after, code group}; sub-blocks flip when unbalanced or 111000/1100, and K 4b groups also flip at negative mid
	function [10:0] encode;
		input [7:0] d;
		input       k;
		input       rd;
		reg   [5:0] s6;
		reg   [3:0] s4;
		reg         mid;
		reg         alt;
		begin
			s6 = (k && d[4:0] == 5'h1c) ? 6'b001111 : TAB6[d[4:0]*6 +: 6];
			if (rd && (weight(s6) != 3'd3 || s6 == 6'b111000))
				s6 = ~s6;
			mid = rd ^ (weight(s6) != 3'd3);
			// Alternate D.x.7 avoids a run of five across the sub-block seam
			alt = (d[7:5] == 3'h7) && (k || (!mid && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14))
				|| (mid && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e)));
			s4 = alt ? 4'b0111 : TAB4[d[7:5]*4 +: 4];
			if (mid && (weight({2'b00, s4}) != 3'd2 || s4 == 4'b1100))
				s4 = ~s4;
			else if (k && !mid && weight({2'b00, s4}) == 3'd2 && s4 != 4'b1100)
				s4 = ~s4;
			encode = {mid ^ (weight({2'b00, s4}) != 3'd2), s6, s4};
		end
	endfunction

	// Decode by matching against every legal group at the current disparity; a miss is invalid
	always @*
	begin
		dec_data = 8'h00;
		dec_k = 1'b0;
		dec_hit = 1'b0;
		dec_rd = ~rx_rd;
		cand = 11'h000;
		for (i = 0; i < 256; i = i + 1)
		begin
			cand = encode(i[7:0], 1'b0, rx_rd);
			if (cand[9:0] == rx_code)
			begin
				dec_hit = 1'b1;
				dec_data = i[7:0];
				dec_rd = cand[10];
			end
		end
		for (i = 0; i < 12; i = i + 1)
		begin
			cand = encode(K_LIST[i*8 +: 8], 1'b1, rx_rd);
			if (cand[9:0] == rx_code)
			begin
				dec_hit = 1'b1;
				dec_k = 1'b1;
				dec_data = K_LIST[i*8 +: 8];
				dec_rd = cand[10];
			end
		end
	end

	// Encoder and decoder registers; both start at negative disparity
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_rd <= 1'b0;
			tx_code <= 10'h000;
			rx_rd <= 1'b0;
			rx_data <= 8'h00;
			rx_k <= 1'b0;
			rx_bad <= 1'b0;
		end
		else
		begin
			{tx_rd, tx_code} <= encode(tx_data, tx_k, tx_rd);
			rx_data <= dec_data;
			rx_k <= dec_k;
			rx_bad <= ~dec_hit;
			rx_rd <= dec_rd;
		end
	end

endmodule

// ===== logic/gp_pcs_top.v
// Gigabit PCS datapath: framing, comma alignment, link sync, de-framing and APB control
// How it works
// - First preamble byte of a frame started on an even slot is replaced by start-of-frame /S/.
// - Frame bytes after start-of-frame go out as plain data code groups.
// - After the last byte send /T/ /R/ /R/ or /T/ /R/ by position parity.
// - Idle ordered sets are sent continuously between frames.
// - Transmit error from the MAC inside a frame becomes a /V/ code group.
// - Encoder keeps the line DC balanced with runs of at most five.
// - Receiver searches all ten bit offsets for a comma and realigns to it.
// - Comma search restarts whenever link synchronisation is lost.
// - Decoder checks running disparity and yields octets for de-framing.
// - Idle followed by /S/ starts a frame; MAC sees 0x55 instead of /S/.
// - Frame bytes go to the MAC until /T/ /R/ /R/ or /T/ /R/ ends it.
// - Received /V/ is passed to the MAC as a frame error.
// - Anything but idle, idle-start or /R/ after /T/ or /R/ outside a frame is false carrier.
// - Invalid code groups inside a frame signal an error to the MAC.
// - Three valid comma groups with no invalid group between them acquire link synchronisation.
// - In sync, invalid groups and misplaced commas raise the error counter.
// - Four good groups in a row lower the counter; reaching four loses sync.
// - Link indicator is high whenever synchronisation is held.
// - Panel link indicator follows sync only while auto-negotiation is disabled.
// - Carrier sense and its LED need sync plus tx or rx machine activity.
// - Collision outputs only in SGMII half duplex with tx and rx traffic together.
// - GMII style port to the MAC, ten-bit code-group port to the SERDES.
// - Serial GMII select clear means 1000BASE-X, set means SGMII.
//
// Chosen here: the APB interface to the registers and the address map.
`include "gp_regs.vh"
module gp_pcs_top
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        mac_tx_en,
	input  wire [7:0]  mac_tx_data,
	input  wire        mac_tx_error_in,
	output reg         mac_rx_dv,
	output reg  [7:0]  mac_rx_data,
	output reg         mac_rx_er,
	output wire        mac_rx_crs,
	output wire        mac_rx_col,
	output wire [9:0]  tbi_tx_code,
	input  wire [9:0]  tbi_rx_code,
	output wire        led_link,
	output wire        led_panel_link,
	output wire        led_crs,
	output wire        led_col
);
	// Transmit framing states
	localparam TX_IDLE = 4'b0001;
	localparam TX_DATA = 4'b0010;
	localparam TX_R1   = 4'b0100;
	localparam TX_R2   = 4'b1000;
	// Link synchronisation states
	localparam SY_LOSS = 2'b01;
	localparam SY_OK   = 2'b10;
	// Receive de-framing states
	localparam RX_IDLE  = 3'b001;
	localparam RX_FRAME = 3'b010;
	localparam RX_FALSE = 3'b100;

	reg  [2:0]  ctrl;
	wire [31:0] status;
	reg  [3:0]  tx_state;
	reg  [3:0]  next_tx_state;
	reg         tx_odd;
	reg  [7:0]  enc_data;
	reg         enc_k;
	wire        tx_disp;
	reg  [9:0]  rx_hold;
	wire [19:0] rx_window;
	wire [9:0]  comma_hit;
	reg         comma_found;
	reg  [3:0]  comma_off;
	reg  [3:0]  align;
	wire [3:0]  sel_off;
	wire [4:0]  sel_base;
	reg  [9:0]  rx_sym;
	reg         sym_comma;
	reg         sym_mis;
	reg         dec_comma;
	reg         dec_mis;
	wire [7:0]  dec_data;
	wire        dec_k;
	wire        dec_bad;
	reg  [1:0]  sy_state;
	reg  [1:0]  comma_cnt;
	reg  [2:0]  err_cnt;
	reg  [2:0]  good_cnt;
	reg         rx_odd;
	wire        synced;
	wire        sync_bad;
	reg  [2:0]  rx_state;
	reg         prev_k;
	reg  [7:0]  prev_data;
	reg         prev_idle_d;
	wire        is_comma;
	wire        is_idle_d;
	wire        is_tail_r;
	wire        crs;
	wire        col;
	wire        apb_setup;
	wire        apb_write;
	wire        hit_ctrl;
	wire        hit_stat;
	integer     k;

	// True when the octet is the given special group
	function is_special;
		input       kf;
		input [7:0] d;
		input [7:0] code;
		begin
			is_special = kf && d == code;
		end
	endfunction

	// APB decode; the slave never waits, so every access phase completes at its first edge
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite;
	assign hit_ctrl = paddr == `GP_CTRL_OFF;
	assign hit_stat = paddr == `GP_STAT_OFF;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_ctrl && !hit_stat;
	assign status = {25'h0000000, err_cnt, 1'b0, col, crs, synced};

	// Control register; status is read-only and writes to it are dropped silently
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl <= `GP_CTRL_RESET;
		else if (apb_write && hit_ctrl)
			ctrl <= pwdata[2:0];
	end

	// Read data is captured in the setup cycle so it is a flop during the access phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (apb_setup && !pwrite)
			prdata <= hit_ctrl ? {29'h00000000, ctrl} : (hit_stat ? status : 32'h00000000);
	end

	// Transmit framing; the position toggle keeps /I/ and the /R/ padding on even boundaries
	always @*
	begin
		next_tx_state = tx_state;
		enc_data = `GP_K28_5;
		enc_k = 1'b1;
		case (tx_state)
			TX_IDLE:
			begin
				if (tx_odd)
				begin
					// Second half of /I/: D5.6 holds negative disparity, D16.2 restores it
					enc_data = tx_disp ? `GP_D16_2 : `GP_D5_6;
					enc_k = 1'b0;
				end
				else if (mac_tx_en)
				begin
					enc_data = `GP_K27_7;
					next_tx_state = TX_DATA;
				end
			end
			TX_DATA:
			begin
				if (!mac_tx_en)
				begin
					enc_data = `GP_K29_7;
					next_tx_state = TX_R1;
				end
				else if (mac_tx_error_in)
					enc_data = `GP_K30_7;
				else
				begin
					enc_data = mac_tx_data;
					enc_k = 1'b0;
				end
			end
			TX_R1:
			begin
				enc_data = `GP_K23_7;
				next_tx_state = tx_odd ? TX_IDLE : TX_R2;
			end
			TX_R2:
			begin
				enc_data = `GP_K23_7;
				next_tx_state = TX_IDLE;
			end
			default:
				next_tx_state = TX_IDLE;
		endcase
	end

	// Framing state and code-group position; a frame that starts on an odd slot loses one preamble byte
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_state <= TX_IDLE;
			tx_odd <= 1'b0;
		end
		else
		begin
			tx_state <= next_tx_state;
			tx_odd <= ~tx_odd;
		end
	end

	// Shared encoder and decoder
	gp_codec u_codec
	(
		.pclk    (pclk),
		.presetn (presetn),
		.tx_data (enc_data),
		.tx_k    (enc_k),
		.tx_code (tbi_tx_code),
		.tx_disp (tx_disp),
		.rx_code (rx_sym),
		.rx_data (dec_data),
		.rx_k    (dec_k),
		.rx_bad  (dec_bad)
	);

	// Comma search over every bit offset of the last two samples, a bit first
	assign rx_window = {rx_hold, tbi_rx_code};
	genvar g;
	generate
		for (g = 0; g < 10; g = g + 1)
		begin : g_comma
			assign comma_hit[g] = rx_window[19-g -: 7] == `GP_COMMA_NEG ||
				rx_window[19-g -: 7] == `GP_COMMA_POS;
		end
	endgenerate

	// Lowest offset that shows a comma
	always @*
	begin
		comma_found = 1'b0;
		comma_off = 4'h0;
		for (k = 9; k >= 0; k = k - 1)
		begin
			if (comma_hit[k])
			begin
				comma_found = 1'b1;
				comma_off = k[3:0];
			end
		end
	end

	// Alignment is free while out of sync and frozen once sync is held
	assign sel_off = (!synced && comma_found) ? comma_off : align;
	assign sel_base = 5'd19 - {1'b0, sel_off};

	// Aligner registers; a comma off the locked boundary is flagged for the sync machine
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_hold <= 10'h000;
			align <= 4'h0;
			rx_sym <= 10'h000;
			sym_comma <= 1'b0;
			sym_mis <= 1'b0;
			dec_comma <= 1'b0;
			dec_mis <= 1'b0;
		end
		else
		begin
			rx_hold <= tbi_rx_code;
			if (!synced && comma_found)
				align <= comma_off;
			rx_sym <= rx_window[sel_base -: 10];
			sym_comma <= comma_hit[sel_off];
			sym_mis <= synced && comma_found && comma_off != align;
			dec_comma <= sym_comma;
			dec_mis <= sym_mis;
		end
	end

	// A group counts against sync if invalid, a comma off boundary, or a comma in an odd slot
	assign synced = sy_state == SY_OK;
	assign sync_bad = dec_bad || dec_mis || (dec_comma && rx_odd);

	// Link synchronisation machine with its error counter
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sy_state <= SY_LOSS;
			comma_cnt <= 2'h0;
			err_cnt <= 3'h0;
			good_cnt <= 3'h0;
			rx_odd <= 1'b0;
		end
		else
		begin
			rx_odd <= ~rx_odd;
			case (sy_state)
				SY_LOSS:
				begin
					if (dec_bad)
						comma_cnt <= 2'h0;
					else if (dec_comma)
					begin
						rx_odd <= 1'b1;
						if (comma_cnt + 2'h1 == `GP_ACQ_COMMAS)
						begin
							sy_state <= SY_OK;
							comma_cnt <= 2'h0;
							err_cnt <= 3'h0;
							good_cnt <= 3'h0;
						end
						else
							comma_cnt <= comma_cnt + 2'h1;
					end
				end
				SY_OK:
				begin
					if (sync_bad)
					begin
						good_cnt <= 3'h0;
						if (err_cnt + 3'h1 == `GP_LOSS_ERRS)
						begin
							sy_state <= SY_LOSS;
							err_cnt <= 3'h0;
						end
						else
							err_cnt <= err_cnt + 3'h1;
					end
					else if (good_cnt + 3'h1 == `GP_GOOD_RUN)
					begin
						good_cnt <= 3'h0;
						if (err_cnt != 3'h0)
							err_cnt <= err_cnt - 3'h1;
					end
					else
						good_cnt <= good_cnt + 3'h1;
				end
				default:
					sy_state <= SY_LOSS;
			endcase
		end
	end

	// Classes of received groups that are legal between frames
	assign is_comma = is_special(dec_k, dec_data, `GP_K28_5);
	assign is_idle_d = !dec_k && !dec_bad && (dec_data == `GP_D5_6 || dec_data == `GP_D16_2) &&
		is_special(prev_k, prev_data, `GP_K28_5);
	assign is_tail_r = is_special(dec_k, dec_data, `GP_K23_7) &&
		(is_special(prev_k, prev_data, `GP_K29_7) || is_special(prev_k, prev_data, `GP_K23_7));

	// De-framing to GMII; every error shows on the byte it belongs to
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_state <= RX_IDLE;
			mac_rx_dv <= 1'b0;
			mac_rx_er <= 1'b0;
			mac_rx_data <= 8'h00;
			prev_k <= 1'b0;
			prev_data <= 8'h00;
			prev_idle_d <= 1'b0;
		end
		else
		begin
			prev_k <= dec_k;
			prev_data <= dec_data;
			prev_idle_d <= is_idle_d;
			mac_rx_dv <= 1'b0;
			mac_rx_er <= 1'b0;
			mac_rx_data <= 8'h00;
			if (!synced)
				rx_state <= RX_IDLE;
			else
			begin
				case (rx_state)
					RX_IDLE:
					begin
						if (is_special(dec_k, dec_data, `GP_K27_7) && prev_idle_d)
						begin
							mac_rx_dv <= 1'b1;
							mac_rx_data <= `GP_PREAMBLE;
							rx_state <= RX_FRAME;
						end
						else if (!(is_comma || is_idle_d || is_tail_r))
						begin
							mac_rx_er <= 1'b1;
							mac_rx_data <= `GP_FALSE_CAR;
							rx_state <= RX_FALSE;
						end
					end
					RX_FRAME:
					begin
						if (is_special(dec_k, dec_data, `GP_K29_7))
							rx_state <= RX_IDLE;
						else if (dec_bad || is_special(dec_k, dec_data, `GP_K30_7))
						begin
							mac_rx_dv <= 1'b1;
							mac_rx_er <= 1'b1;
						end
						else if (dec_k)
						begin
							// Any other special group cuts the frame short and is flagged bad
							mac_rx_dv <= 1'b1;
							mac_rx_er <= 1'b1;
							rx_state <= RX_IDLE;
						end
						else
						begin
							mac_rx_dv <= 1'b1;
							mac_rx_data <= dec_data;
						end
					end
					RX_FALSE:
					begin
						if (is_comma)
							rx_state <= RX_IDLE;
						else
						begin
							mac_rx_er <= 1'b1;
							mac_rx_data <= `GP_FALSE_CAR;
						end
					end
					default:
						rx_state <= RX_IDLE;
				endcase
			end
		end
	end

	// Indications; collision needs SGMII, half duplex, and both directions busy
	assign crs = synced && (tx_state != TX_IDLE || rx_state != RX_IDLE);
	assign col = ctrl[`GP_CTRL_SGMII] && ctrl[`GP_CTRL_HALF] && tx_state != TX_IDLE &&
		rx_state == RX_FRAME;
	assign mac_rx_crs = crs;
	assign led_crs = crs;
	assign mac_rx_col = col;
	assign led_col = col;
	assign led_link = synced;
	assign led_panel_link = synced && !ctrl[`GP_CTRL_AN];

endmodule

// ===== logic/gp_regs.vh
// Register offsets, field positions, code groups and counts for the gigabit PCS datapath
`ifndef GP_REGS_VH
`define GP_REGS_VH

// Register byte offsets on the APB port
`define GP_CTRL_OFF     8'h00
`define GP_STAT_OFF     8'h04

// Control register fields and reset value
`define GP_CTRL_RESET   3'h0
`define GP_CTRL_SGMII   0
`define GP_CTRL_AN      1
`define GP_CTRL_HALF    2

// Status register fields
`define GP_STAT_SYNC    0
`define GP_STAT_CRS     1
`define GP_STAT_COL     2
`define GP_STAT_ERR_LSB 4

// Octets of the special and data code groups used by the framing logic
`define GP_K28_5        8'hbc
`define GP_K27_7        8'hfb
`define GP_K29_7        8'hfd
`define GP_K23_7        8'hf7
`define GP_K30_7        8'hfe
`define GP_D16_2        8'h50
`define GP_D5_6         8'hc5
`define GP_PREAMBLE     8'h55
`define GP_FALSE_CAR    8'h0e

// Seven-bit comma patterns in bit positions a..g
`define GP_COMMA_NEG    7'h1f
`define GP_COMMA_POS    7'h60

// Link synchronisation counts
`define GP_ACQ_COMMAS   2'h3
`define GP_LOSS_ERRS    3'h4
`define GP_GOOD_RUN     3'h4

`endif

// ===== verif/gp_pcs_monitor.sv
// Concurrent checks on the gigabit PCS top-level ports
`include "gp_regs.vh"
module gp_pcs_monitor
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       mac_tx_en,
	input wire logic       mac_tx_error_in,
	input wire logic       mac_rx_dv,
	input wire logic [7:0] mac_rx_data,
	input wire logic       mac_rx_er,
	input wire logic       mac_rx_crs,
	input wire logic       mac_rx_col,
	input wire logic [9:0] tbi_tx_code,
	input wire logic       led_link,
	input wire logic       led_panel_link,
	input wire logic       led_crs,
	input wire logic       led_col
);
	timeunit 1ns;
	timeprecision 100ps;
	// Single clock domain, so one clocking and one disable serve all checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// First group after reset is a negative-disparity comma
	a_reset_idle_start: assert property ($rose(presetn) |=> tbi_tx_code == 10'h0fa)
		else $error("First group after reset is not K28.5 RD-");
	// Start group within two groups of frame start, one slot lost on an odd start
	a_tx_sof: assert property ($rose(mac_tx_en) |-> ##[1:2] tbi_tx_code inside {10'h368, 10'h097})
		else $error("Start group missing after frame start");
	// Flagged byte inside a running frame becomes the error group
	a_tx_error_v: assert property (mac_tx_en && mac_tx_error_in && $past(mac_tx_en) && $past(mac_tx_en, 2)
		|=> tbi_tx_code inside {10'h1e8, 10'h217})
		else $error("Transmit error not encoded as error group");
	// Frame end gives terminate then carrier extend
	a_tx_eof_seq: assert property ($fell(mac_tx_en) && $past(mac_tx_en, 2)
		|=> tbi_tx_code inside {10'h2e8, 10'h117} ##1 tbi_tx_code inside {10'h3a8, 10'h057})
		else $error("End-of-frame sequence missing");
	// Once the tail has drained only idle groups may go out
	a_tx_idle_only: assert property (!mac_tx_en [*6] |=>
		tbi_tx_code inside {10'h0fa, 10'h305, 10'h296, 10'h1b5, 10'h245})
		else $error("Non-idle group sent outside a frame");
	// Receive path stays quiet while sync is lost
	a_rx_gated_nosync: assert property (!led_link [*4] |-> !mac_rx_dv && !mac_rx_er)
		else $error("Receive activity without link sync");
	// Panel indicator can only show a link that is held
	a_panel_link: assert property (led_panel_link |-> led_link)
		else $error("Panel link lit without sync");
	// Carrier and its lamp agree and need sync
	a_crs_led: assert property (led_crs == mac_rx_crs && (!mac_rx_crs || led_link))
		else $error("Carrier sense or lamp wrong");
	// Collision lamp mirrors the collision output
	a_col_led: assert property (led_col == mac_rx_col)
		else $error("Collision lamp differs from collision output");
	// False carrier uses the error encoding with valid low
	a_false_carrier: assert property (mac_rx_er && !mac_rx_dv |-> mac_rx_data == `GP_FALSE_CAR)
		else $error("False carrier code wrong");
endmodule

bind gp_pcs_top gp_pcs_monitor gp_pcs_monitor_inst
(
	.pclk(pclk), .presetn(presetn), .mac_tx_en(mac_tx_en), .mac_tx_error_in(mac_tx_error_in),
	.mac_rx_dv(mac_rx_dv), .mac_rx_data(mac_rx_data), .mac_rx_er(mac_rx_er), .mac_rx_crs(mac_rx_crs),
	.mac_rx_col(mac_rx_col), .tbi_tx_code(tbi_tx_code), .led_link(led_link),
	.led_panel_link(led_panel_link), .led_crs(led_crs), .led_col(led_col)
);

// ===== verif/gp_serdes_model.sv
// Loopback ten-bit SERDES model with bit slip and group corruption
module gp_serdes_model
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [9:0] tx_code,
	input  wire logic [3:0] slip,
	input  wire logic       corrupt,
	output logic      [9:0] rx_code
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [9:0] prev_code;
	// Slip moves the sampling window earlier, so the receiver must realign
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_code <= 10'h000;
			rx_code   <= 10'h3ff;
		end
		else
		begin
			prev_code <= tx_code;
			rx_code   <= corrupt ? 10'h000 : 10'(({prev_code, tx_code} >> slip));
		end
	end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench: PCS transmit looped back to receive through a SERDES model
`include "gp_regs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [2:0] ctrl; logic [7:0] start; int len; int err_at; logic col;} gp_row_t;
	// Control value, frame shape and expected collision per row
	gp_row_t     rows [4] = '{'{3'h0, 8'h10, 8, -1, 1'b0}, '{3'h3, 8'hb8, 9, 3, 1'b0},
		'{3'h5, 8'hf0, 12, -1, 1'b1}, '{3'h4, 8'h40, 11, 5, 1'b0}};
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic        mac_tx_en = 1'b0;
	logic [7:0]  mac_tx_data = 8'h00;
	logic        mac_tx_error_in = 1'b0;
	logic [3:0]  slip = 4'h0;
	logic        corrupt = 1'b0;
	wire  [31:0] prdata;
	wire  [7:0]  mac_rx_data;
	wire  [9:0]  tbi_tx_code, tbi_rx_code;
	wire         pready, pslverr, mac_rx_dv, mac_rx_er, mac_rx_crs, mac_rx_col;
	wire         led_link, led_panel_link, led_crs, led_col;
	logic [8:0]  rxq [$];
	logic        saw_col, saw_crs, e;
	logic [31:0] q;
	int          num_errors = 0;
	int          compares = 0;
	int          col_cnt = 0;
	int          crs_cnt = 0;
	int          i;

	gp_pcs_top gp_pcs_top_inst
	(
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mac_tx_en(mac_tx_en),
		.mac_tx_data(mac_tx_data), .mac_tx_error_in(mac_tx_error_in), .mac_rx_dv(mac_rx_dv),
		.mac_rx_data(mac_rx_data), .mac_rx_er(mac_rx_er), .mac_rx_crs(mac_rx_crs), .mac_rx_col(mac_rx_col),
		.tbi_tx_code(tbi_tx_code), .tbi_rx_code(tbi_rx_code), .led_link(led_link),
		.led_panel_link(led_panel_link), .led_crs(led_crs), .led_col(led_col)
	);
	gp_serdes_model gp_serdes_model_inst
	(
		.pclk(pclk), .presetn(presetn), .tx_code(tbi_tx_code), .slip(slip), .corrupt(corrupt),
		.rx_code(tbi_rx_code)
	);

	initial forever #12.5 pclk = ~pclk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("Compares %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// One APB transfer; the leading edge keeps back-to-back calls from colliding
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Send one frame and compare what comes back on the MAC receive side
	task automatic send_frame(input logic [7:0] start, input int len, input int err_at);
		int n;
		int base;
		int col_base;
		int crs_base;
		// Marks instead of clearing, so the collector stays the only writer of its records
		base = rxq.size();
		col_base = col_cnt;
		crs_base = crs_cnt;
		// Start on an even slot so no byte is dropped ahead of the start group
		for (n = 0; n < 40 && !(tbi_tx_code inside {10'h0fa, 10'h305}); n++)
			@(posedge pclk);
		for (n = 0; n < len; n++)
		begin
			mac_tx_en <= 1'b1;
			mac_tx_data <= start + n[7:0];
			mac_tx_error_in <= (n == err_at);
			@(posedge pclk);
		end
		mac_tx_en <= 1'b0;
		mac_tx_error_in <= 1'b0;
		for (n = 0; n < 40 && (rxq.size() == base || mac_rx_dv !== 1'b0); n++)
			@(posedge pclk);
		saw_col = col_cnt != col_base;
		saw_crs = crs_cnt != crs_base;
		chk(rxq.size() - base, len);
		chk(rxq[base], {1'b0, `GP_PREAMBLE});
		for (n = 1; n < len; n++)
			chk(rxq[base + n], (n == err_at) ? 9'h100 : {1'b0, start + n[7:0]});
	endtask

	task automatic wait_link(input logic v);
		int n;
		for (n = 0; n < 300 && led_link !== v; n++)
			@(posedge pclk);
	endtask

	task automatic hit(input int n);
		corrupt <= 1'b1;
		repeat (n) @(posedge pclk);
		corrupt <= 1'b0;
	endtask

	// Collect received bytes with their error flag; note carrier and collision
	always @(posedge pclk)
	begin
		if (mac_rx_dv === 1'b1)
			rxq.push_back({mac_rx_er, mac_rx_data});
		if (mac_rx_col === 1'b1)
			col_cnt <= col_cnt + 1;
		if (mac_rx_crs === 1'b1)
			crs_cnt <= crs_cnt + 1;
	end

	// Several times the normal run length
	initial
	begin
		repeat (8000) @(posedge pclk);
		num_errors++;
		conclude();
	end

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(led_link, 1'b0);
		apb(1'b0, `GP_CTRL_OFF, 32'h0, q, e);
		chk(q, 32'h0);
		apb(1'b0, 8'h08, 32'h0, q, e);
		chk(q, 32'h0);
		chk({31'h0, e}, 32'h1);
		wait_link(1'b1);
		chk(led_link, 1'b1);
		apb(1'b0, `GP_STAT_OFF, 32'h0, q, e);
		chk(q[`GP_STAT_SYNC], 1'b1);
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, `GP_CTRL_OFF, {29'h0, rows[i].ctrl}, q, e);
			send_frame(rows[i].start, rows[i].len, rows[i].err_at);
			chk(saw_col, rows[i].col);
			chk(saw_crs, 1'b1);
			chk(led_panel_link, !rows[i].ctrl[`GP_CTRL_AN]);
		end
		// Invalid group between frames, then error counts either side of the loss limit
		hit(1);
		for (i = 0; i < 12 && !(mac_rx_er === 1'b1 && mac_rx_dv === 1'b0); i++)
			@(posedge pclk);
		chk(mac_rx_data, `GP_FALSE_CAR);
		repeat (30) @(posedge pclk);
		hit(3);
		repeat (12) @(posedge pclk);
		chk(led_link, 1'b1);
		repeat (30) @(posedge pclk);
		hit(4);
		wait_link(1'b0);
		chk(led_link, 1'b0);
		wait_link(1'b1);
		chk(led_link, 1'b1);
		// Shift the bit boundary: misplaced commas drop sync, then search realigns
		slip <= 4'h3;
		wait_link(1'b0);
		chk(led_link, 1'b0);
		wait_link(1'b1);
		chk(led_link, 1'b1);
		send_frame(8'h20, 8, -1);
		conclude();
	end
endmodule
